// >>> rtl/cmp_bc_pkg.sv
package cmp_bc_pkg;

  localparam int          ADDR_W        = 9;
  localparam int          BUS_ADDR_W    = 24;
  localparam int          BUS_DATA_W    = 32;

  // byte offsets of the register window
  localparam logic [8:0]  OFS_B_ADDR    = 9'h125;
  localparam logic [8:0]  OFS_C_CTL     = 9'h130;
  localparam logic [8:0]  OFS_C_ADDR    = 9'h135;
  localparam logic [8:0]  OFS_C_DATA    = 9'h138;
  localparam logic [8:0]  OFS_C_MASK    = 9'h13c;
  localparam logic [8:0]  OFS_DBG_CTL   = 9'h100;
  localparam logic [8:0]  OFS_DBG_STAT  = 9'h101;

  // control register field positions
  localparam int          CTL_INV_BIT   = 6;
  localparam int          CTL_PC_BIT    = 5;
  localparam int          CTL_DIR_BIT   = 3;
  localparam int          CTL_RWE_BIT   = 2;
  localparam int          CTL_EN_BIT    = 0;
  localparam logic [7:0]  CTL_WR_MASK   = 8'h6d;
  localparam int          ARM_BIT       = 7;
  localparam int          PROFILING_TRACE_ACTIVE_BIT     = 0;

  localparam logic [23:0] ADDR_RST      = 24'h000000;
  localparam logic [31:0] DATA_RST      = 32'h00000000;
  localparam logic [7:0]  CTL_RST       = 8'h00;

  typedef struct packed {
    logic        valid;
    logic        is_pc;
    logic        rd;
    logic        narrow;
    logic [23:0] addr;
    logic [31:0] data;
  } bus_obs_t;

  typedef struct packed {
    logic [23:0] b_addr;
    logic [7:0]  c_ctl;
    logic [23:0] c_addr;
    logic [31:0] c_data;
    logic [31:0] c_mask;
    logic        armed;
    logic [7:0]  rdata;
    logic        match_b;
    logic        match_c;
  } state_t;

endpackage : cmp_bc_pkg

// >>> rtl/debug_bus_comparator_b_c.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - config writes only when unarmed, trace inactive
// - 24-bit address values for B and C
// - control bit 6 inverts data match
// - data inversion ignored in pc mode
// - control bit 5 selects pc address
// - control bit 2 enables direction qualification
// - bit 3: 0 writes, 1 reads
// - direction bit ignored unless qualifying, data mode
// - direction must equal bus read signal
// - pc mode ignores direction bits
// - control bit 0 enables comparator C
// - 32-bit data compare value
// - data bit compared only if mask set
// - data register byte addressable, msb first
// - narrow master data uses low half
// - mask zero excludes data bit
// - pc match flagged at execute stage
// - arming bit makes comparators operational
module debug_bus_comparator_b_c
  import cmp_bc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              profiling_trace_active,
  input  wire bus_obs_t          bus_obs,
  output logic                   match_b,
  output logic                   match_c,
  output logic                   armed
);

  state_t s_q;
  state_t s_d;

  //////////////////////////////////////////////////////////////////////////////

  // every stored address bit must agree
  function automatic logic addr_equal(input logic [23:0] a, input logic [23:0] v);
    addr_equal = (a == v);
  endfunction : addr_equal

  // data compare only where the mask is set
  function automatic logic masked_equal(input logic [31:0] d, input logic [31:0] v,
                                        input logic [31:0] m);
    masked_equal = ((d ^ v) & m) == 32'h00000000;
  endfunction : masked_equal

  // direction qualifier only in data mode
  function automatic logic dir_qualify(input logic [7:0] ctl, input logic rd);
    dir_qualify = 1'b1;
    if (!ctl[CTL_PC_BIT] && ctl[CTL_RWE_BIT]) begin
      dir_qualify = (ctl[CTL_DIR_BIT] == rd);
    end
  endfunction : dir_qualify

  // narrow master only drives the low half
  function automatic logic [31:0] lane_mask(input logic [31:0] mask, input logic narrow);
    lane_mask = mask;
    if (narrow) begin
      lane_mask = {16'h0000, mask[15:0]};
    end
  endfunction : lane_mask

  // polarity select, dropped for pc events
  function automatic logic data_qualify(input logic [7:0] ctl, input logic eq);
    data_qualify = 1'b1;
    if (!ctl[CTL_PC_BIT]) begin
      data_qualify = ctl[CTL_INV_BIT] ? !eq : eq;
    end
  endfunction : data_qualify

  logic        cfg_open;
  logic        wr_cfg;
  logic [7:0]  rd_mux;
  logic        addr_b_hit;
  logic        addr_c_hit;
  logic        dir_ok;
  logic [31:0] cmp_mask;
  logic        data_eq;
  logic        data_ok;

  // config bytes lock while armed or tracing
  assign cfg_open = !s_q.armed && !profiling_trace_active;
  assign wr_cfg   = reg_wr && cfg_open;

  //////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      // comparator b address, msb at lowest address
      OFS_B_ADDR: begin
        rd_mux = s_q.b_addr[23:16];
      end

      OFS_B_ADDR + 9'h001: begin
        rd_mux = s_q.b_addr[15:8];
      end

      OFS_B_ADDR + 9'h002: begin
        rd_mux = s_q.b_addr[7:0];
      end

      // comparator c control
      OFS_C_CTL: begin
        rd_mux = s_q.c_ctl;
      end

      // comparator c address
      OFS_C_ADDR: begin
        rd_mux = s_q.c_addr[23:16];
      end

      OFS_C_ADDR + 9'h001: begin
        rd_mux = s_q.c_addr[15:8];
      end

      OFS_C_ADDR + 9'h002: begin
        rd_mux = s_q.c_addr[7:0];
      end

      // comparator c data, msb first
      OFS_C_DATA: begin
        rd_mux = s_q.c_data[31:24];
      end

      OFS_C_DATA + 9'h001: begin
        rd_mux = s_q.c_data[23:16];
      end

      OFS_C_DATA + 9'h002: begin
        rd_mux = s_q.c_data[15:8];
      end

      OFS_C_DATA + 9'h003: begin
        rd_mux = s_q.c_data[7:0];
      end

      // comparator c data mask
      OFS_C_MASK: begin
        rd_mux = s_q.c_mask[31:24];
      end

      OFS_C_MASK + 9'h001: begin
        rd_mux = s_q.c_mask[23:16];
      end

      OFS_C_MASK + 9'h002: begin
        rd_mux = s_q.c_mask[15:8];
      end

      OFS_C_MASK + 9'h003: begin
        rd_mux = s_q.c_mask[7:0];
      end

      // debug control and status
      OFS_DBG_CTL: begin
        rd_mux = {s_q.armed, 7'h00};
      end

      OFS_DBG_STAT: begin
        rd_mux = {6'h00, s_q.match_c, s_q.match_b};
      end

      // unmapped bytes read as zero
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // match logic

  assign addr_b_hit = addr_equal(bus_obs.addr, s_q.b_addr);
  assign addr_c_hit = addr_equal(bus_obs.addr, s_q.c_addr);

  assign dir_ok   = dir_qualify(s_q.c_ctl, bus_obs.rd);
  assign cmp_mask = lane_mask(s_q.c_mask, bus_obs.narrow);

  assign data_eq  = masked_equal(bus_obs.data, s_q.c_data, cmp_mask);
  assign data_ok  = data_qualify(s_q.c_ctl, data_eq);

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d         = s_q;
    // read data stands one cycle, zero otherwise
    s_d.rdata   = reg_rd ? rd_mux : 8'h00;

    // arm bit stays writable so software can always disarm
    if (reg_wr && reg_addr == OFS_DBG_CTL) begin
      s_d.armed = reg_wdata[ARM_BIT];
    end

    if (wr_cfg) begin
      case (reg_addr)
        // comparator b address
        OFS_B_ADDR: begin
          s_d.b_addr[23:16] = reg_wdata;
        end

        OFS_B_ADDR + 9'h001: begin
          s_d.b_addr[15:8] = reg_wdata;
        end

        OFS_B_ADDR + 9'h002: begin
          s_d.b_addr[7:0] = reg_wdata;
        end

        // comparator c control
        OFS_C_CTL: begin
          // bits 1, 4 and 7 are not kept and read zero
          s_d.c_ctl = reg_wdata & CTL_WR_MASK;
        end

        // comparator c address
        OFS_C_ADDR: begin
          s_d.c_addr[23:16] = reg_wdata;
        end

        OFS_C_ADDR + 9'h001: begin
          s_d.c_addr[15:8] = reg_wdata;
        end

        OFS_C_ADDR + 9'h002: begin
          s_d.c_addr[7:0] = reg_wdata;
        end

        // comparator c data, msb at lowest address
        OFS_C_DATA: begin
          s_d.c_data[31:24] = reg_wdata;
        end

        OFS_C_DATA + 9'h001: begin
          s_d.c_data[23:16] = reg_wdata;
        end

        OFS_C_DATA + 9'h002: begin
          s_d.c_data[15:8] = reg_wdata;
        end

        OFS_C_DATA + 9'h003: begin
          s_d.c_data[7:0] = reg_wdata;
        end

        // comparator c data mask
        OFS_C_MASK: begin
          s_d.c_mask[31:24] = reg_wdata;
        end

        OFS_C_MASK + 9'h001: begin
          s_d.c_mask[23:16] = reg_wdata;
        end

        OFS_C_MASK + 9'h002: begin
          s_d.c_mask[15:8] = reg_wdata;
        end

        OFS_C_MASK + 9'h003: begin
          s_d.c_mask[7:0] = reg_wdata;
        end

        default: begin
        end
      endcase
    end

    // pc events arrive already qualified at execute stage
    s_d.match_b = s_q.armed && bus_obs.valid
                  && addr_b_hit;
    s_d.match_c = s_q.armed && bus_obs.valid && s_q.c_ctl[CTL_EN_BIT]
                  && (bus_obs.is_pc == s_q.c_ctl[CTL_PC_BIT])
                  && addr_c_hit && dir_ok && data_ok;
  end

  // async reset clears all state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q.b_addr  <= ADDR_RST;
      s_q.c_ctl   <= CTL_RST;
      s_q.c_addr  <= ADDR_RST;
      s_q.c_data  <= DATA_RST;
      s_q.c_mask  <= DATA_RST;
      s_q.armed   <= 1'b0;
      s_q.rdata   <= 8'h00;
      s_q.match_b <= 1'b0;
      s_q.match_c <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign match_b   = s_q.match_b;
  assign match_c   = s_q.match_c;
  assign armed     = s_q.armed;

endmodule : debug_bus_comparator_b_c

// >>> tb/cmp_bc_properties.sv
`timescale 1ns/1ps
module cmp_bc_properties
  import cmp_bc_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              profiling_trace_active,
  input wire bus_obs_t          bus_obs,
  input wire logic              match_b,
  input wire logic              match_c,
  input wire logic              armed
);
  logic [7:0] ctl_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // shadow of the control byte
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n) ctl_q <= CTL_RST;
    else if (reg_wr && reg_addr == OFS_C_CTL && !armed && !profiling_trace_active)
      ctl_q <= reg_wdata & CTL_WR_MASK;
  property p_rd0; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("rdata not idle");
  property p_rdc; reg_rd && reg_addr == OFS_C_CTL |=> reg_rdata == ctl_q; endproperty
  a_rdc: assert property (p_rdc) else $error("control readback");
  property p_arm; !armed |=> !match_b && !match_c; endproperty
  a_arm: assert property (p_arm) else $error("match while unarmed");
  property p_armw; reg_wr && reg_addr == OFS_DBG_CTL |=> armed == $past(reg_wdata[ARM_BIT]);
  endproperty
  a_armw: assert property (p_armw) else $error("arm bit");
  property p_idle; !bus_obs.valid |=> !match_b && !match_c; endproperty
  a_idle: assert property (p_idle) else $error("match without event");
  property p_off; !ctl_q[CTL_EN_BIT] |=> !match_c; endproperty
  a_off: assert property (p_off) else $error("match while disabled");
  property p_kind; bus_obs.valid && bus_obs.is_pc != ctl_q[CTL_PC_BIT] |=> !match_c; endproperty
  a_kind: assert property (p_kind) else $error("wrong event kind");
  property p_dir; bus_obs.valid && !ctl_q[CTL_PC_BIT] && ctl_q[CTL_RWE_BIT]
    && bus_obs.rd != ctl_q[CTL_DIR_BIT] |=> !match_c; endproperty
  a_dir: assert property (p_dir) else $error("direction");
endmodule : cmp_bc_properties
bind debug_bus_comparator_b_c cmp_bc_properties u_props (
  .clk_sys                (clk_sys),
  .arst_n                 (arst_n),
  .reg_addr               (reg_addr),
  .reg_wdata              (reg_wdata),
  .reg_wr                 (reg_wr),
  .reg_rd                 (reg_rd),
  .reg_rdata              (reg_rdata),
  .profiling_trace_active (profiling_trace_active),
  .bus_obs                (bus_obs),
  .match_b                (match_b),
  .match_c                (match_c),
  .armed                  (armed)
);

// >>> tb/bus_src.sv
`timescale 1ns/1ps
module bus_src
  import cmp_bc_pkg::*;
(
  input  wire logic clk_sys,
  output bus_obs_t  bus_obs
);
  initial bus_obs = '0;
  task automatic emit(input logic [2:0] k, input logic [23:0] a, input logic [31:0] d,
                      input int g);
    repeat (g) @(posedge clk_sys);
    @(posedge clk_sys);
    bus_obs <= {1'b1, k, a, d};
    @(posedge clk_sys);
    // idle address and data lines show no stale value, kind bits keep theirs
    bus_obs <= {1'b0, k, ~a, ~d};
  endtask : emit
endmodule : bus_src

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import cmp_bc_pkg::*;
  localparam logic [23:0] ca = 24'habcdef;
  localparam logic [31:0] dv = 32'h11223344;
  logic       clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       profiling_trace_active = 1'b0, match_b, match_c, armed;
  logic [8:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata;
  bus_obs_t   bus_obs;
  int         n_errors = 0, n_checks = 0;
  debug_bus_comparator_b_c dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .profiling_trace_active, .bus_obs, .match_b, .match_c, .armed);
  bus_src src (.clk_sys, .bus_obs);
  initial forever #12.5 clk_sys = ~clk_sys;
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  // four bytes, most significant first
  task automatic wn(input logic [8:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(a + 9'(i), v[8*(3-i) +: 8]);
  endtask : wn
  task automatic ev(input logic [7:0] c, input logic [2:0] k, input logic [31:0] d,
                    input logic e);
    wr(OFS_DBG_CTL, 8'h00);
    wr(OFS_C_CTL, c);
    wr(OFS_DBG_CTL, 8'h80);
    src.emit(k, ca, d, 0);
    #1 `CHK({match_b, match_c}, {1'b0, e})
  endtask : ev
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(OFS_C_CTL, CTL_RST);
    wn(9'h124, 32'h00123456);
    wn(9'h134, {8'h00, ca});
    wn(OFS_C_DATA, dv);
    wn(OFS_C_MASK, 32'hffffffff);
    rd(9'h138, 8'h11);
    rd(9'h13b, 8'h44);
    rd(9'h137, 8'hef);
    rd(9'h134, 8'h00);
    wr(OFS_C_CTL, 8'hff);
    rd(OFS_C_CTL, CTL_WR_MASK);
    $display("test regs done");
    ev(8'h01, 3'b000, dv, 1'b1);
    ev(8'h01, 3'b000, dv ^ 32'h100, 1'b0);
    ev(8'h41, 3'b000, dv ^ 32'h100, 1'b1);
    ev(8'h41, 3'b000, dv, 1'b0);
    ev(8'h0d, 3'b000, dv, 1'b0);
    ev(8'h0d, 3'b010, dv, 1'b1);
    ev(8'h05, 3'b010, dv, 1'b0);
    ev(8'h09, 3'b000, dv, 1'b1);
    ev(8'h6d, 3'b100, dv, 1'b1);
    ev(8'h21, 3'b000, dv, 1'b0);
    ev(8'h01, 3'b100, dv, 1'b0);
    ev(8'h00, 3'b000, dv, 1'b0);
    ev(8'h01, 3'b001, 32'h55663344, 1'b1);
    wr(OFS_DBG_CTL, 8'h00);
    wn(OFS_C_MASK, 32'h0000ffff);
    ev(8'h01, 3'b000, 32'hffff3344, 1'b1);
    `CHK(armed, 1'b1)
    src.emit(3'b000, 24'h123456, dv, 3);
    #1 `CHK({match_b, match_c}, 2'b10)
    $display("test match done");
    wr(OFS_C_CTL, 8'h00);
    rd(OFS_C_CTL, 8'h01);
    wr(OFS_DBG_CTL, 8'h00);
    profiling_trace_active <= 1'b1;
    wr(OFS_C_CTL, 8'h00);
    rd(OFS_C_CTL, 8'h01);
    $display("test lock done");
    conclude();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end
endmodule : tb_top
